// file: design/tsc_pkg.sv
// Package: register map, field layout and carriers of the thermal supervisor control bank
package tsc_pkg;

    // ------------------------------------------------------------
    // Command bytes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CONTROL = 8'h03;
    localparam logic [7:0] CMD_MASK = 8'h04;
    localparam logic [7:0] CMD_LHIGH = 8'h05;
    localparam logic [7:0] RST_CONTROL = 8'h80;
    localparam logic [7:0] RST_MASK = 8'h07;
    localparam logic [7:0] RST_LHIGH = 8'h3c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_IE = 7;
    localparam int CTL_LPM = 6;
    localparam int CTL_FQ_HI = 5;
    localparam int CTL_FQ_LO = 4;
    localparam int CTL_RES_HI = 3;
    localparam int CTL_RES_LO = 2;
    localparam int CTL_REINIT = 0;
    localparam int MSK_DIODE = 2;
    localparam int MSK_ROT = 1;
    localparam int MSK_LOT = 0;
    // Writable bits; reserved positions read as zero
    localparam logic [7:0] CTL_WMASK = 8'hfc;
    localparam logic [7:0] MSK_WMASK = 8'hff;

    // Cycles the start-of-sequence strobe trails the abort strobe
    localparam int RESTART_DLY = 1;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] cmd;
        logic [7:0] wdata;
    } tsc_req_s;

    typedef struct packed {
        logic lock_local_overtemp;
        logic lock_remote_overtemp;
        logic lock_shutdown;
        logic lock_warm_reinit;
    } tsc_lock_s;

    typedef struct packed {
        logic       global_interrupt_enable;
        logic       low_power_mode;
        logic [2:0] fault_queue_depth;
        logic [3:0] remote_adc_precision;
    } tsc_cfg_s;

endpackage

// file: design/tsc_depth_dec.sv
// Decoders of the fault queue depth and remote precision codes
`timescale 1ns/10ps
module tsc_depth_dec (
    input wire logic [1:0] i_fq_code,   // Fault queue depth code
    input wire logic [1:0] i_res_code,  // Remote precision code
    output logic [2:0] o_depth,         // Consecutive faults needed
    output logic [3:0] o_bits           // Conversion width in bits
);
    always_comb begin
        unique case (i_fq_code)
            2'h0: o_depth = 3'h1;
            2'h1: o_depth = 3'h2;
            2'h2: o_depth = 3'h4;
            2'h3: o_depth = 3'h6;
        endcase
        o_bits = 4'h9 + {2'h0, i_res_code};
    end
endmodule // tsc_depth_dec

// file: design/tsc_wr_dec.sv
// Command byte decoder for register accesses
`timescale 1ns/10ps
module tsc_wr_dec (
    input wire tsc_pkg::tsc_req_s i_req,  // Register request
    output logic o_wr_ctl,                // Write of control_settings
    output logic o_wr_msk,                // Write of event_enable_mask
    output logic o_wr_lhi,                // Write of local_high_limit
    output logic o_hit                    // Command is mapped
);
    always_comb begin
        o_wr_ctl = i_req.wr && (i_req.cmd == tsc_pkg::CMD_CONTROL);
        o_wr_msk = i_req.wr && (i_req.cmd == tsc_pkg::CMD_MASK);
        o_wr_lhi = i_req.wr && (i_req.cmd == tsc_pkg::CMD_LHIGH);
        o_hit = (i_req.cmd == tsc_pkg::CMD_CONTROL) ||
                (i_req.cmd == tsc_pkg::CMD_MASK) ||
                (i_req.cmd == tsc_pkg::CMD_LHIGH);
    end
endmodule // tsc_wr_dec

// file: design/tsc_regs.sv
// Control register bank of the thermal supervisor
`timescale 1ns/10ps
module tsc_regs (
    input wire logic i_clk_sys,                 // System clock, 10 MHz
    input wire logic i_rst_n,                   // Sync reset, active low
    input wire tsc_pkg::tsc_req_s i_req,        // Command byte access
    input wire tsc_pkg::tsc_lock_s i_lock,      // Lock bits of the device
    output logic [7:0] o_rdata,                 // Read data, registered
    output logic o_rvalid,                      // Read answer strobe
    output tsc_pkg::tsc_cfg_s o_cfg,            // Decoded settings
    output logic [7:0] o_event_enable_mask,     // Effective event mask
    output logic signed [7:0] o_local_high_limit, // Local high limit
    output logic o_purge_all_queues,            // Purge every fault queue
    output logic o_purge_local_high_queue,      // Purge local high queue
    output logic o_adc_abort,                   // Abort and discard result
    output logic o_adc_restart,                 // Begin new sequence
    output logic o_warm_reinit                  // Reinit of all functions
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] msk;
        logic [7:0] lhi;
        logic [7:0] rdata;
        logic rvalid;
        tsc_pkg::tsc_cfg_s cfg;
        logic [7:0] eff_msk;
        logic purge_all;
        logic purge_lhi;
        logic abort;
        logic restart;
        logic reinit;
    } tsc_state_s;

    tsc_state_s st_q;
    tsc_state_s st_d;
    logic wr_ctl;
    logic wr_msk;
    logic wr_lhi;
    logic hit;
    logic [2:0] depth;
    logic [3:0] bits;
    logic [7:0] ctl_eff;
    logic [7:0] msk_eff;
    logic do_reinit;
    logic [1:0] fq_code;
    logic [1:0] res_code;

    tsc_wr_dec u_dec (
        .i_req(i_req),
        .o_wr_ctl(wr_ctl),
        .o_wr_msk(wr_msk),
        .o_wr_lhi(wr_lhi),
        .o_hit(hit)
    );

    tsc_depth_dec u_depth (
        .i_fq_code(fq_code),
        .i_res_code(res_code),
        .o_depth(depth),
        .o_bits(bits)
    );

    // Reinit is refused while the warm-reinit lock holds
    assign do_reinit = wr_ctl && i_req.wdata[tsc_pkg::CTL_REINIT] &&
                       !i_lock.lock_warm_reinit;
    // Codes that the next edge stores; no loop through st_d
    assign fq_code = do_reinit ?
        tsc_pkg::RST_CONTROL[tsc_pkg::CTL_FQ_HI:tsc_pkg::CTL_FQ_LO] :
        wr_ctl ? i_req.wdata[tsc_pkg::CTL_FQ_HI:tsc_pkg::CTL_FQ_LO] :
        st_q.ctl[tsc_pkg::CTL_FQ_HI:tsc_pkg::CTL_FQ_LO];
    assign res_code = do_reinit ?
        tsc_pkg::RST_CONTROL[tsc_pkg::CTL_RES_HI:tsc_pkg::CTL_RES_LO] :
        wr_ctl ? i_req.wdata[tsc_pkg::CTL_RES_HI:tsc_pkg::CTL_RES_LO] :
        st_q.ctl[tsc_pkg::CTL_RES_HI:tsc_pkg::CTL_RES_LO];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.rvalid = 1'b0;
        st_d.purge_all = 1'b0;
        st_d.purge_lhi = 1'b0;
        st_d.abort = 1'b0;
        st_d.reinit = 1'b0;
        // Restart follows the abort once the write is done
        st_d.restart = st_q.abort;
        // Reserved bits are dropped on write
        if (wr_ctl) begin
            st_d.ctl = i_req.wdata & tsc_pkg::CTL_WMASK;
            st_d.purge_all = 1'b1;
            st_d.abort = 1'b1;
        end
        if (wr_msk) begin
            st_d.msk = i_req.wdata & tsc_pkg::MSK_WMASK;
        end
        if (wr_lhi) begin
            st_d.lhi = i_req.wdata;
            st_d.purge_lhi = 1'b1;
        end
        if (do_reinit) begin
            st_d.ctl = tsc_pkg::RST_CONTROL;
            st_d.msk = tsc_pkg::RST_MASK;
            st_d.lhi = tsc_pkg::RST_LHIGH;
            st_d.reinit = 1'b1;
        end
        // Lock forcing is applied to the stored bits
        ctl_eff = st_d.ctl;
        msk_eff = st_d.msk;
        if (i_lock.lock_local_overtemp) begin
            msk_eff[tsc_pkg::MSK_LOT] = 1'b1;
            ctl_eff[tsc_pkg::CTL_IE] = 1'b1;
        end
        if (i_lock.lock_remote_overtemp) begin
            msk_eff[tsc_pkg::MSK_ROT] = 1'b1;
            ctl_eff[tsc_pkg::CTL_IE] = 1'b1;
        end
        if (i_lock.lock_shutdown) begin
            ctl_eff[tsc_pkg::CTL_LPM] = 1'b0;
        end
        st_d.ctl = ctl_eff;
        st_d.msk = msk_eff;
        st_d.eff_msk = msk_eff;
        st_d.cfg.global_interrupt_enable = ctl_eff[tsc_pkg::CTL_IE];
        st_d.cfg.low_power_mode = ctl_eff[tsc_pkg::CTL_LPM];
        st_d.cfg.fault_queue_depth = depth;
        st_d.cfg.remote_adc_precision = bits;
        // Reads return current contents; unmapped reads give zero
        if (i_req.rd) begin
            st_d.rvalid = 1'b1;
            if (!hit) begin
                st_d.rdata = 8'h00;
            end else if (i_req.cmd == tsc_pkg::CMD_CONTROL) begin
                st_d.rdata = st_q.ctl;
            end else if (i_req.cmd == tsc_pkg::CMD_MASK) begin
                st_d.rdata = st_q.msk;
            end else begin
                st_d.rdata = st_q.lhi;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_q <= '0;
            st_q.ctl <= tsc_pkg::RST_CONTROL;
            st_q.msk <= tsc_pkg::RST_MASK;
            st_q.lhi <= tsc_pkg::RST_LHIGH;
            st_q.cfg.global_interrupt_enable <= 1'b1;
            st_q.cfg.fault_queue_depth <= 3'h1;
            st_q.cfg.remote_adc_precision <= 4'h9;
            st_q.eff_msk <= tsc_pkg::RST_MASK;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rdata;
    assign o_rvalid = st_q.rvalid;
    assign o_cfg = st_q.cfg;
    assign o_event_enable_mask = st_q.eff_msk;
    assign o_local_high_limit = st_q.lhi;
    assign o_purge_all_queues = st_q.purge_all;
    assign o_purge_local_high_queue = st_q.purge_lhi;
    assign o_adc_abort = st_q.abort;
    assign o_adc_restart = st_q.restart;
    assign o_warm_reinit = st_q.reinit;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence ctl_write_s;
        i_req.wr && i_req.cmd == tsc_pkg::CMD_CONTROL;
    endsequence

    sequence abort_then_restart_s;
        o_adc_abort && o_purge_all_queues ##1 o_adc_restart;
    endsequence

    // Control write with no reinit and no forcing lock
    sequence free_ctl_write_s;
        i_req.wr && i_req.cmd == tsc_pkg::CMD_CONTROL &&
        !i_req.wdata[tsc_pkg::CTL_REINIT] && !i_lock.lock_shutdown &&
        !i_lock.lock_local_overtemp && !i_lock.lock_remote_overtemp;
    endsequence

    sequence reinit_write_s;
        i_req.wr && i_req.cmd == tsc_pkg::CMD_CONTROL &&
        i_req.wdata[tsc_pkg::CTL_REINIT] && !i_lock.lock_warm_reinit;
    endsequence

    // Forcing locks leave the power-up values unchanged
    sequence defaults_back_s;
        o_warm_reinit && st_q.ctl == tsc_pkg::RST_CONTROL &&
        st_q.msk == tsc_pkg::RST_MASK &&
        o_local_high_limit == tsc_pkg::RST_LHIGH;
    endsequence

    sequence mask_write_s;
        i_req.wr && i_req.cmd == tsc_pkg::CMD_MASK &&
        !i_lock.lock_local_overtemp && !i_lock.lock_remote_overtemp;
    endsequence

    ctl_abort_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        ctl_write_s |=> abort_then_restart_s)
        else $error("control write did not abort and restart");
    restart_order_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_adc_restart |-> $past(o_adc_abort))
        else $error("restart without prior abort");
    purge_cause_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_purge_all_queues |-> $past(i_req.wr) &&
        $past(i_req.cmd) == tsc_pkg::CMD_CONTROL)
        else $error("queues purged without control write");
    reset_ctl_a: assert property (
        @(posedge i_clk_sys)
        $rose(i_rst_n) |-> st_q.ctl == tsc_pkg::RST_CONTROL)
        else $error("control reset value wrong");
    reset_msk_a: assert property (
        @(posedge i_clk_sys)
        $rose(i_rst_n) |-> o_event_enable_mask == tsc_pkg::RST_MASK)
        else $error("mask reset value wrong");
    reset_lhi_a: assert property (
        @(posedge i_clk_sys)
        $rose(i_rst_n) |-> o_local_high_limit == tsc_pkg::RST_LHIGH)
        else $error("limit reset value wrong");
    ie_write_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        free_ctl_write_s |=>
        o_cfg.global_interrupt_enable == $past(i_req.wdata[7]))
        else $error("interrupt enable not taken from write");
    lpm_write_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        free_ctl_write_s |=>
        o_cfg.low_power_mode == $past(i_req.wdata[6]))
        else $error("low-power mode not taken from write");
    reinit_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        reinit_write_s |=> defaults_back_s)
        else $error("reinit did not restore defaults");
    mask_write_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        mask_write_s |=> o_event_enable_mask == $past(i_req.wdata))
        else $error("mask write not stored");
    lhi_purge_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_req.wr && i_req.cmd == tsc_pkg::CMD_LHIGH |=>
        o_purge_local_high_queue && o_local_high_limit == $past(i_req.wdata))
        else $error("limit write not stored or purged");
    read_ctl_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_req.rd && i_req.cmd == tsc_pkg::CMD_CONTROL |=>
        o_rvalid && o_rdata == $past(st_q.ctl))
        else $error("control read wrong");
    read_msk_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_req.rd && i_req.cmd == tsc_pkg::CMD_MASK |=>
        o_rvalid && o_rdata == $past(st_q.msk))
        else $error("mask read wrong");
    read_lhi_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_req.rd && i_req.cmd == tsc_pkg::CMD_LHIGH |=>
        o_rvalid && o_rdata == $past(st_q.lhi))
        else $error("limit read wrong");
    reinit_lock_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_lock.lock_warm_reinit |=> !o_warm_reinit)
        else $error("reinit taken while locked");
    lot_lock_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_lock.lock_local_overtemp |=> o_event_enable_mask[0] &&
        o_cfg.global_interrupt_enable)
        else $error("local overtemp lock not held");
    rot_lock_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_lock.lock_remote_overtemp |=> o_event_enable_mask[1] &&
        o_cfg.global_interrupt_enable)
        else $error("remote overtemp lock not held");
    low_power_mode_lock_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_lock.lock_shutdown |=> !o_cfg.low_power_mode)
        else $error("shutdown lock not held");
    depth_one_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        st_q.ctl[5:4] == 2'h0 |-> o_cfg.fault_queue_depth == 3'h1)
        else $error("depth code 00 not one");
    depth_two_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        st_q.ctl[5:4] == 2'h1 |-> o_cfg.fault_queue_depth == 3'h2)
        else $error("depth code 01 not two");
    depth_six_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        st_q.ctl[5:4] == 2'h3 |-> o_cfg.fault_queue_depth == 3'h6)
        else $error("depth code 11 not six");
    prec_nine_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        st_q.ctl[3:2] == 2'h0 |-> o_cfg.remote_adc_precision == 4'h9)
        else $error("precision code 00 not nine");
    prec_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        st_q.ctl[3:2] == 2'h2 |-> o_cfg.remote_adc_precision == 4'hb)
        else $error("precision code 10 not eleven");

endmodule // tsc_regs

// file: tb/tsc_host_model.sv
// Host model issuing command byte reads and writes to the bank
`timescale 1ns/10ps
module tsc_host_model (
    input wire logic i_clk_sys,      // System clock
    output tsc_pkg::tsc_req_s o_req  // Request to the bank
);
    initial o_req = '0;
    // One strobe cycle per access, raised just after an edge
    task automatic access(input logic wr, input logic [7:0] cmd,
                          input logic [7:0] data);
        @(posedge i_clk_sys);
        #1;
        o_req.wr = wr;
        o_req.rd = ~wr;
        o_req.cmd = cmd;
        o_req.wdata = (cmd == tsc_pkg::CMD_CONTROL) ? (data & 8'hfd) :
                      data;
        @(posedge i_clk_sys);
        #1;
        o_req.wr = 1'b0;
        o_req.rd = 1'b0;
        o_req.wdata = ~o_req.wdata;
    endtask
endmodule // tsc_host_model

// file: tb/tsc_regs_bench.sv
// Self-checking bench of the control register bank
`timescale 1ns/10ps
module tsc_regs_bench;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    tsc_pkg::tsc_req_s req;
    tsc_pkg::tsc_lock_s lock = '0;
    tsc_pkg::tsc_cfg_s cfg;
    logic [7:0] rdata, emask;
    logic signed [7:0] lhigh;
    logic rvalid, p_all, p_lhi, abort, restart, reinit;
    wire logic [4:0] pulses = {p_all, abort, p_lhi, reinit, restart};
    int errors = 0, comparisons = 0, seed = 47280, cycles = 0;
    int ctl, msk, lhi, i;
    logic [7:0] d, c;

    always #50 i_clk_sys = ~i_clk_sys;

    tsc_host_model host (.i_clk_sys(i_clk_sys), .o_req(req));
    tsc_regs uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(req),
        .i_lock(lock), .o_rdata(rdata), .o_rvalid(rvalid), .o_cfg(cfg),
        .o_event_enable_mask(emask), .o_local_high_limit(lhigh),
        .o_purge_all_queues(p_all), .o_purge_local_high_queue(p_lhi),
        .o_adc_abort(abort), .o_adc_restart(restart),
        .o_warm_reinit(reinit));

    // ------------------------------------------------------------
    // Reference model and comparison
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic defaults();
        ctl = 8'h80;
        msk = 8'h07;
        lhi = 8'h3c;
    endtask

    task automatic apply_locks();
        if (lock.lock_local_overtemp) msk = msk | 1;
        if (lock.lock_remote_overtemp) msk = msk | 2;
        if (lock.lock_local_overtemp || lock.lock_remote_overtemp)
            ctl = ctl | 8'h80;
        if (lock.lock_shutdown) ctl = ctl & 8'hbf;
    endtask

    task automatic check_state();
        logic [2:0] dep;
        logic [8:0] exp_cfg;
        dep = (ctl[5:4] == 2'b00) ? 3'h1 : {ctl[5:4], 1'b0};
        exp_cfg = {ctl[7], ctl[6], dep, 4'h9 + ctl[3:2]};
        check(cfg, exp_cfg);
        check(emask, msk[7:0]);
        check({8'h00, lhigh}, lhi[7:0]);
    endtask

    task automatic op(input logic wr, input logic [7:0] cmd,
                      input logic [7:0] dat);
        int rd_exp;
        logic cw, rein;
        logic [4:0] pexp;
        rd_exp = 0;
        cw = wr && cmd == 8'h03;
        rein = cw && dat[0] && !lock.lock_warm_reinit;
        pexp = {cw, cw, wr && cmd == 8'h05, rein, 1'b0};
        if (!wr)
            rd_exp = cmd == 8'h03 ? ctl : cmd == 8'h04 ? msk :
                     cmd == 8'h05 ? lhi : 0;
        if (rein) defaults();
        else if (cw) ctl = dat & 8'hfc;
        else if (wr && cmd == 8'h04) msk = dat;
        else if (wr && cmd == 8'h05) lhi = dat;
        apply_locks();
        host.access(wr, cmd, dat);
        check(rvalid, !wr);
        if (!wr) check(rdata, rd_exp[7:0]);
        check(pulses, pexp);
        check_state();
        @(posedge i_clk_sys);
        #1;
        check(pulses, {4'h0, cw});
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        defaults();
        repeat (12) @(posedge i_clk_sys);
        #1;
        i_rst_n = 1'b1;
        check_state();
        for (i = 2; i < 7; i++) op(1'b0, i[7:0], 8'h00);
        // Every depth and precision code
        for (i = 0; i < 4; i++) op(1'b1, 8'h03, {4'h8, i[1:0], i[1:0]} << 2);
        for (i = 0; i < 160; i++) begin
            if (i % 16 == 15) begin
                lock = 4'($random(seed));
                apply_locks();
                repeat (3) @(posedge i_clk_sys);
                #1;
                check_state();
            end
            c = 8'h02 + 8'($unsigned($random(seed)) % 5);
            d = 8'($random(seed));
            if (c == 8'h03 && ($random(seed) & 3) != 0) d[0] = 1'b0;
            op(1'($random(seed)), c, d);
        end
        // Reset in mid-run
        lock = '0;
        @(posedge i_clk_sys);
        #1;
        i_rst_n = 1'b0;
        repeat (2) @(posedge i_clk_sys);
        #1;
        i_rst_n = 1'b1;
        defaults();
        check_state();
        op(1'b0, 8'h03, 8'h00);
        stop_test();
    end
endmodule // tsc_regs_bench
